// ==== sar_adc_regs.vh ====
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// register byte offsets
`define OFS_CTL            8'h00
`define OFS_TRG            8'h04
`define OFS_CFG            8'h08
`define OFS_FLAG           8'h0c
`define OFS_IRQ_EN         8'h10
`define OFS_RESULT_BASE    8'h20
`define OFS_RESULT_LAST    8'h3c

// control register fields
`define CTL_ENABLE_BIT     0
`define CTL_START_BIT      1
`define CTL_BUSY_BIT       10
`define CTL_CUR_LSB        12
`define CTL_CUR_MSB        14

// trigger / input select register fields
`define TRG_SAMPLE_LSB     0
`define TRG_SAMPLE_MSB     2
`define TRG_SRC_LSB        4
`define TRG_SRC_MSB        5
`define TRG_MODE_BIT       6
`define TRG_ALIGN_BIT      7
`define TRG_FIRST_LSB      8
`define TRG_FIRST_MSB      10
`define TRG_LAST_LSB       11
`define TRG_LAST_MSB       13

// configuration register fields
`define CFG_VRANGE_LSB     0
`define CFG_VRANGE_MSB     1

// flag and enable layout: done flags low byte, overwrite flags high byte
`define FLAG_DONE_LSB      0
`define FLAG_OVER_LSB      8

// reset values
`define RST_SAMPLE_SEL     3'h7
`define RST_TRG_SRC        2'h0
`define RST_VRANGE         2'h0
`define RST_INPUT          3'h0

// trigger source codes
`define SRC_SOFTWARE       2'h0
`define SRC_TIMER          2'h1
`define SRC_EXTERNAL       2'h3

// timing in converter clock cycles
`define SAMPLE_BASE_CYCLES 4'h4
`define CONV_CYCLES        4'hd

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== axil_reg_port.v ====
`timescale 1ns/1ns
module axil_reg_port (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address and data
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // register side
  output wire        wr_en,
  output wire [7:0]  wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0]  wr_strb,
  input  wire        wr_hit,
  output wire [7:0]  rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_hit
);
  `include "sar_adc_regs.vh"

  reg        aw_have_q;
  reg        w_have_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  // address and data are held until both are present
  assign awready = ~aw_have_q & ~bvalid;
  assign wready  = ~w_have_q & ~bvalid;
  assign wr_en   = aw_have_q & w_have_q & ~bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign arready = ~rvalid;
  assign rd_addr = araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `RESP_OKAY;
      rdata     <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_hit ? rd_data : 32'h0000_0000;
        rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== sar_adc_sequencer_control.v ====
`timescale 1ns/1ns
// How it works
// - each input is sampled for a programmable 4 to 11 converter clock cycles
// - one conversion takes the sampling cycles plus 13 more converter cycles
// - external source: start bit arms, falling edge on trigger pin starts
// - timer source: start bit arms, each timer underflow starts a sequence
// - software source: writing one to a cleared start bit starts the sequence
// - triggers are accepted only while not busy, ignored while busy
// - an accepted trigger starts sampling on the next converter clock tick
// - clearing the start bit lets the running conversion finish, then stops
// - inputs from first to last are converted one after another, ascending
// - one-time mode stops after each input in range is converted once
// - continuous mode repeats the range until the start bit is cleared
// - loading a result sets that input's done flag, cleared by writing one
// - loading over a set done flag sets overwrite flag, cleared by writing one
// - overwrite never halts conversion and ignores whether the result was read
// - interrupt request is raised only for set flags whose enable is one
// - 12-bit result sits in bits 11:0 or bits 15:4 per alignment select
// - trigger select 0x0 software, 0x1 timer, 0x3 external pin, 0x2 reserved
// - sample select 0x0 to 0x7 maps linearly to 4 to 11 cycles
// - mode bit one selects continuous mode, zero one-time mode
// - busy reads one while converting and zero while idle
module sar_adc_sequencer_control (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write channels
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  // axi4-lite read channels
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // timing and trigger sources
  input  wire        conv_clock,
  input  wire        timer_underflow,
  input  wire        ext_trigger_pin,
  // analog core
  output reg  [2:0]  analog_input_pin,
  output reg         core_sample,
  output reg         core_convert,
  input  wire [11:0] core_result,
  output reg  [1:0]  voltage_range_select,
  // interrupt request
  output wire        irq_request
);
  `include "sar_adc_regs.vh"

  localparam ST_IDLE   = 2'd0;
  localparam ST_SYNC   = 2'd1;
  localparam ST_SAMPLE = 2'd2;
  localparam ST_CONV   = 2'd3;

  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;

  // control and configuration
  reg         module_enable_bit_q;
  reg         conv_start_bit_q;
  reg  [2:0]  sample_cycles_select_q;
  reg  [1:0]  trigger_select_q;
  reg         conv_mode_select_q;
  reg         result_align_select_q;
  reg  [2:0]  first_input_select_q;
  reg  [2:0]  last_input_select_q;
  reg  [15:0] irq_enable_q;

  // sequencer
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [3:0]  cyc_q;
  reg  [3:0]  cyc_d;
  reg  [2:0]  cur_q;
  reg  [2:0]  cur_d;
  reg         ext_pin_prev_q;
  reg  [7:0]  done_q;
  reg  [7:0]  over_q;
  reg  [11:0] result_mem [0:7];

  function [15:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // shared by both the read and the write decode
  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a[1:0] == 2'b00) &&
                    ((a == `OFS_CTL) || (a == `OFS_TRG) || (a == `OFS_CFG) ||
                     (a == `OFS_FLAG) || (a == `OFS_IRQ_EN) ||
                     ((a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST)));
    end
  endfunction

  axil_reg_port u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (addr_mapped(wr_addr)),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_hit  (addr_mapped(rd_addr))
  );

  wire [15:0] wmask    = lane_mask(wr_strb);
  wire [15:0] wval     = wr_data[15:0];
  wire        wr_ctl   = wr_en && (wr_addr == `OFS_CTL);
  wire        wr_trg   = wr_en && (wr_addr == `OFS_TRG);
  wire        wr_cfg   = wr_en && (wr_addr == `OFS_CFG);
  wire        wr_flag  = wr_en && (wr_addr == `OFS_FLAG);
  wire        wr_irqen = wr_en && (wr_addr == `OFS_IRQ_EN);
  wire [15:0] flag_clr = wr_flag ? (wval & wmask) : 16'h0000;

  wire conv_busy_flag = (state_q != ST_IDLE);
  wire start_rise = wr_ctl && wr_strb[0] && wval[`CTL_START_BIT] && !conv_start_bit_q;
  wire ext_fall   = ext_pin_prev_q && !ext_trigger_pin;
  wire armed      = module_enable_bit_q && conv_start_bit_q;

  // trigger acceptance by source; reserved code never triggers
  reg trig_event;
  always @* begin
    trig_event = 1'b0;
    case (trigger_select_q)
      `SRC_SOFTWARE: trig_event = module_enable_bit_q && start_rise;
      `SRC_TIMER:    trig_event = armed && timer_underflow;
      `SRC_EXTERNAL: trig_event = armed && ext_fall;
      default:       trig_event = 1'b0;
    endcase
  end

  wire trig_accept = trig_event && !conv_busy_flag;
  wire [3:0] sample_len = `SAMPLE_BASE_CYCLES + {1'b0, sample_cycles_select_q};
  wire conv_done = (state_q == ST_CONV) && conv_clock && (cyc_q == `CONV_CYCLES - 4'h1);
  // start bit as it stands after a write in this same cycle
  wire start_now = (wr_ctl && wr_strb[0]) ? wval[`CTL_START_BIT] : conv_start_bit_q;

  always @* begin
    state_d = state_q;
    cyc_d   = cyc_q;
    cur_d   = cur_q;
    case (state_q)
      ST_IDLE: begin
        if (trig_accept) begin
          state_d = ST_SYNC;
          cur_d   = first_input_select_q;
          cyc_d   = 4'h0;
        end
      end
      ST_SYNC: begin
        if (conv_clock) begin
          state_d = ST_SAMPLE;
          cyc_d   = 4'h0;
        end
      end
      ST_SAMPLE: begin
        if (conv_clock) begin
          if (cyc_q == sample_len - 4'h1) begin
            state_d = ST_CONV;
            cyc_d   = 4'h0;
          end else begin
            cyc_d = cyc_q + 4'h1;
          end
        end
      end
      ST_CONV: begin
        if (conv_clock) begin
          cyc_d = cyc_q + 4'h1;
        end
        if (conv_done) begin
          cyc_d = 4'h0;
          if (!start_now) begin
            state_d = ST_IDLE;
          end else if (cur_q < last_input_select_q) begin
            state_d = ST_SAMPLE;
            cur_d   = cur_q + 3'h1;
          end else if (conv_mode_select_q) begin
            state_d = ST_SAMPLE;
            cur_d   = first_input_select_q;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q        <= ST_IDLE;
      cyc_q          <= 4'h0;
      cur_q          <= `RST_INPUT;
      ext_pin_prev_q <= 1'b1;
      core_sample    <= 1'b0;
      core_convert   <= 1'b0;
      analog_input_pin <= `RST_INPUT;
    end else begin
      state_q          <= state_d;
      cyc_q            <= cyc_d;
      cur_q            <= cur_d;
      ext_pin_prev_q   <= ext_trigger_pin;
      core_sample      <= (state_d == ST_SAMPLE);
      core_convert     <= (state_d == ST_CONV);
      analog_input_pin <= cur_d;
    end
  end

  // results and flags; a new set wins over a same-cycle clear
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : g_input
      wire load = conv_done && (cur_q == m);
      always @(posedge aclk) begin
        if (!aresetn) begin
          done_q[m]     <= 1'b0;
          over_q[m]     <= 1'b0;
          result_mem[m] <= 12'h000;
        end else begin
          if (load) begin
            result_mem[m] <= core_result;
          end
          done_q[m] <= (done_q[m] & ~flag_clr[`FLAG_DONE_LSB + m]) | load;
          // decided from the done flag only; sequencing is not affected
          over_q[m] <= (over_q[m] & ~flag_clr[`FLAG_OVER_LSB + m]) | (load & done_q[m]);
        end
      end
    end
  endgenerate

  // software-visible control state
  always @(posedge aclk) begin
    if (!aresetn) begin
      module_enable_bit_q    <= 1'b0;
      conv_start_bit_q       <= 1'b0;
      sample_cycles_select_q <= `RST_SAMPLE_SEL;
      trigger_select_q       <= `RST_TRG_SRC;
      conv_mode_select_q     <= 1'b0;
      result_align_select_q  <= 1'b0;
      first_input_select_q   <= `RST_INPUT;
      last_input_select_q    <= `RST_INPUT;
      voltage_range_select   <= `RST_VRANGE;
      irq_enable_q           <= 16'h0000;
    end else begin
      // start bit is never cleared by hardware
      if (wr_ctl && wr_strb[0]) begin
        module_enable_bit_q <= wval[`CTL_ENABLE_BIT];
        conv_start_bit_q    <= wval[`CTL_START_BIT];
      end
      if (wr_trg && wr_strb[0]) begin
        sample_cycles_select_q <= wval[`TRG_SAMPLE_MSB:`TRG_SAMPLE_LSB];
        trigger_select_q       <= wval[`TRG_SRC_MSB:`TRG_SRC_LSB];
        conv_mode_select_q     <= wval[`TRG_MODE_BIT];
        result_align_select_q  <= wval[`TRG_ALIGN_BIT];
      end
      if (wr_trg && wr_strb[1]) begin
        first_input_select_q <= wval[`TRG_FIRST_MSB:`TRG_FIRST_LSB];
        last_input_select_q  <= wval[`TRG_LAST_MSB:`TRG_LAST_LSB];
      end
      if (wr_cfg && wr_strb[0]) begin
        voltage_range_select <= wval[`CFG_VRANGE_MSB:`CFG_VRANGE_LSB];
      end
      if (wr_irqen) begin
        irq_enable_q <= (irq_enable_q & ~wmask) | (wval & wmask);
      end
    end
  end

  wire [15:0] flag_register = {over_q, done_q};
  assign irq_request = |(flag_register & irq_enable_q);

  // alignment applies at read time, so a change shows at once on every result
  wire [2:0]  rd_idx = rd_addr[4:2];
  wire [11:0] rd_res = result_mem[rd_idx];
  always @* begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `OFS_CTL: begin
        rd_data[`CTL_ENABLE_BIT]          = module_enable_bit_q;
        rd_data[`CTL_START_BIT]           = conv_start_bit_q;
        rd_data[`CTL_BUSY_BIT]            = conv_busy_flag;
        rd_data[`CTL_CUR_MSB:`CTL_CUR_LSB] = cur_q;
      end
      `OFS_TRG: begin
        rd_data[`TRG_SAMPLE_MSB:`TRG_SAMPLE_LSB] = sample_cycles_select_q;
        rd_data[`TRG_SRC_MSB:`TRG_SRC_LSB]       = trigger_select_q;
        rd_data[`TRG_MODE_BIT]                   = conv_mode_select_q;
        rd_data[`TRG_ALIGN_BIT]                  = result_align_select_q;
        rd_data[`TRG_FIRST_MSB:`TRG_FIRST_LSB]   = first_input_select_q;
        rd_data[`TRG_LAST_MSB:`TRG_LAST_LSB]     = last_input_select_q;
      end
      `OFS_CFG: begin
        rd_data[`CFG_VRANGE_MSB:`CFG_VRANGE_LSB] = voltage_range_select;
      end
      `OFS_FLAG: begin
        rd_data[15:0] = flag_register;
      end
      `OFS_IRQ_EN: begin
        rd_data[15:0] = irq_enable_q;
      end
      default: begin
        if (rd_addr >= `OFS_RESULT_BASE && rd_addr <= `OFS_RESULT_LAST) begin
          rd_data[15:0] = result_align_select_q ? {rd_res, 4'h0} : {4'h0, rd_res};
        end
      end
    endcase
  end
endmodule

// ==== sar_adc_sequencer_control_checker.sv ====
`timescale 1ns/1ns
module sar_adc_checker (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // bus handshakes
  input wire       bvalid,
  input wire       bready,
  input wire [1:0] bresp,
  input wire       arvalid,
  input wire       arready,
  input wire       rvalid,
  // converter side
  input wire       conv_clock,
  input wire       core_sample,
  input wire       core_convert,
  input wire [2:0] analog_input_pin
);
  reg [3:0] s_cnt_q;
  reg [4:0] c_cnt_q;
  // pulses inside each phase, still held in the cycle after it ends
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_cnt_q <= 4'h0;
      c_cnt_q <= 5'h00;
    end else begin
      s_cnt_q <= core_sample ? s_cnt_q + {3'h0, conv_clock} : 4'h0;
      c_cnt_q <= core_convert ? c_cnt_q + {4'h0, conv_clock} : 5'h00;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sample_len; $fell(core_sample) |-> s_cnt_q >= 4'h4 && s_cnt_q <= 4'hb; endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample phase length out of range");
  property p_conv_len; $fell(core_convert) |-> c_cnt_q == 5'h0d; endproperty
  a_conv_len: assert property (p_conv_len) else $error("convert phase length wrong");
  property p_sync; $rose(core_sample) && !$past(core_convert) |-> $past(conv_clock); endproperty
  a_sync: assert property (p_sync) else $error("sampling began off a converter tick");
  property p_conv_start; $rose(core_convert) |-> $past(conv_clock) && $past(core_sample); endproperty
  a_conv_start: assert property (p_conv_start) else $error("convert began without sampling");
  property p_pin_hold; core_convert && $past(core_convert) |-> $stable(analog_input_pin); endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("input changed while converting");
  property p_next_pin;
    $fell(core_convert) && core_sample |->
      analog_input_pin == $past(analog_input_pin) + 3'h1 || analog_input_pin <= $past(analog_input_pin);
  endproperty
  a_next_pin: assert property (p_next_pin) else $error("input not ascending");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  c_wrap: cover property ($fell(core_convert) && core_sample && analog_input_pin <= $past(analog_input_pin));
  c_stop: cover property ($fell(core_convert) && !core_sample);
  c_write: cover property (bvalid && bready);
endmodule

// ==== analog_core_model.sv ====
`timescale 1ns/1ns
module analog_core_model #(
  parameter DIV = 3
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [2:0]  analog_input_pin,
  input  wire        core_convert,
  input  wire [11:0] level_base,
  output reg         conv_clock,
  output wire [11:0] core_result
);
  reg [3:0] div_q;
  // converter clock runs free, one tick every DIV cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      conv_clock <= 1'b0;
    end else begin
      div_q <= (div_q == DIV - 1) ? 4'h0 : div_q + 4'h1;
      conv_clock <= (div_q == DIV - 1);
    end
  end
  // outside conversion the value is gone: show its inverse
  assign core_result = core_convert ? level_base + {9'h0, analog_input_pin} : ~(level_base + {9'h0, analog_input_pin});
endmodule

// ==== sar_adc_sequencer_control_test.sv ====
`timescale 1ns/1ns
`include "sar_adc_regs.vh"
module sar_adc_sequencer_control_test;
  localparam [1:0] OK = `RESP_OKAY;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg         timer_underflow = 1'b0, ext_trigger_pin = 1'b1, align, prev_s = 1'b0;
  reg  [11:0] level_base = 12'h0;
  wire        awready, wready, bvalid, arready, rvalid, conv_clock, core_sample, core_convert, irq_request;
  wire [1:0]  bresp, rresp, voltage_range_select;
  wire [31:0] rdata;
  wire [2:0]  analog_input_pin;
  wire [11:0] core_result;
  integer     err_total = 0, total_checks = 0, i, n;
  reg  [2:0]  sel, first, last, pins[$];
  reg  [1:0]  src;
  reg  [31:0] rd;
  reg  [3:0]  pulses = 4'h0;
  always #50 aclk = ~aclk;
  sar_adc_sequencer_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_clock,
    .timer_underflow, .ext_trigger_pin, .analog_input_pin, .core_sample, .core_convert, .core_result,
    .voltage_range_select, .irq_request);
  analog_core_model model (.aclk, .aresetn, .analog_input_pin, .core_convert, .level_base, .conv_clock, .core_result);
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge aclk) begin
    prev_s <= core_sample;
    pulses <= core_sample ? pulses + {3'h0, conv_clock} : 4'h0;
    if (core_sample && !prev_s)
      pins.push_back(analog_input_pin);
    if (!core_sample && prev_s)
      chk("sample pulses", {29'h0, sel} + 32'h4, {28'h0, pulses});
  end
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task axr(input [7:0] a, input [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  function [7:0] range_mask(input [2:0] f, input [2:0] l);
    integer j;
    for (j = 0; j < 8; j = j + 1)
      range_mask[j] = (j >= f) && (j <= l);
  endfunction
  function [31:0] exp_res(input [2:0] p);
    exp_res = {20'h0, level_base + {9'h0, p}};
    if (align)
      exp_res = exp_res << 4;
  endfunction
  task cfg(input [1:0] s, input md, input al);
    {first, last} = 6'($urandom);
    if (last < first)
      {first, last} = {last, first};
    sel = 3'($urandom);
    // corners: full range at longest sampling, one top input at shortest
    if (s == `SRC_EXTERNAL) {first, last, sel} = {3'h0, 3'h7, 3'h7};
    if (s == `SRC_TIMER) {first, last, sel} = {3'h7, 3'h7, 3'h0};
    align = al;
    axw(`OFS_TRG, {18'h0, last, first, al, md, s, 1'b0, sel}, OK);
  endtask
  task fire(input [1:0] s);
    @(posedge aclk);
    timer_underflow <= (s == `SRC_TIMER);
    ext_trigger_pin <= (s != `SRC_EXTERNAL);
    @(posedge aclk);
    timer_underflow <= 1'b0;
    ext_trigger_pin <= 1'b1;
  endtask
  task wait_idle;
    n = 0;
    do begin
      axr(`OFS_CTL, OK);
      n = n + 1;
    end while (rd[`CTL_BUSY_BIT] !== 1'b0 && n < 600);
    chk("busy", 32'h0, {31'h0, rd[`CTL_BUSY_BIT]});
  endtask
  task check_run(input [7:0] ovr);
    integer k;
    axr(`OFS_FLAG, OK);
    chk("flags", {16'h0, ovr, range_mask(first, last)}, rd);
    axr(`OFS_CTL, OK);
    chk("current input", {29'h0, last}, {29'h0, rd[`CTL_CUR_MSB:`CTL_CUR_LSB]});
    chk("run length", {29'h0, last - first} + 32'h1, 32'(pins.size()));
    for (k = 0; k < pins.size(); k = k + 1)
      chk("input order", {29'h0, first} + k, {29'h0, pins[k]});
    for (k = first; k <= last; k = k + 1) begin
      axr(8'(`OFS_RESULT_BASE + 4 * k), OK);
      chk("result", exp_res(3'(k)), rd);
    end
    pins.delete();
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    void'($urandom(32'hf2ac0c93));
    level_base = 12'($urandom);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`OFS_TRG, OK);
    chk("trg reset", {29'h0, `RST_SAMPLE_SEL}, rd);
    axr(`OFS_CTL, OK);
    chk("ctl reset", 32'h0, rd);
    axr(8'h40, `RESP_SLVERR);
    chk("unmapped read", 32'h0, rd);
    axw(8'h44, 32'h3, `RESP_SLVERR);
    axw(`OFS_CTL, 32'h1, OK);
    for (i = 0; i < 5; i = i + 1) begin
      src = (i == 1) ? `SRC_TIMER : (i == 2) ? `SRC_EXTERNAL : `SRC_SOFTWARE;
      if (i < 4) cfg(src, 1'b0, i[0]);
      if (i == 0) begin
        axw(`OFS_CFG, 32'h3, OK);
        chk("voltage range", 32'h3, {30'h0, voltage_range_select});
        axw(`OFS_FLAG, 32'hffff, OK);
      end
      axw(`OFS_CTL, 32'h3, OK);
      if (src != `SRC_SOFTWARE) begin
        axr(`OFS_CTL, OK);
        chk("armed only", 32'h0, {31'h0, rd[`CTL_BUSY_BIT]});
        fire(src);
        repeat (20) @(posedge aclk);
        fire(src);
      end
      axr(`OFS_CTL, OK);
      chk("busy running", 32'h1, {31'h0, rd[`CTL_BUSY_BIT]});
      wait_idle;
      // the last pass repeats the previous one over flags left set
      check_run(i == 4 ? range_mask(first, last) : 8'h00);
      axw(`OFS_CTL, 32'h1, OK);
      if (i != 3) axw(`OFS_FLAG, 32'hffff, OK);
    end
    cfg(2'h2, 1'b0, 1'b0);
    axw(`OFS_CTL, 32'h3, OK);
    fire(`SRC_TIMER);
    fire(`SRC_EXTERNAL);
    repeat (100) @(posedge aclk);
    axr(`OFS_FLAG, OK);
    chk("reserved source", 32'h0, rd + 32'(pins.size()));
    axw(`OFS_CTL, 32'h1, OK);
    cfg(`SRC_SOFTWARE, 1'b1, 1'b0);
    axw(`OFS_CTL, 32'h3, OK);
    n = 0;
    while (pins.size() < last - first + 3 && n < 3000) begin
      @(posedge aclk);
      n = n + 1;
    end
    axw(`OFS_CTL, 32'h1, OK);
    axr(`OFS_CTL, OK);
    chk("busy after stop", 32'h1, {31'h0, rd[`CTL_BUSY_BIT]});
    wait_idle;
    chk("stop count", {29'h0, last - first} + 32'h3, 32'(pins.size()));
    n = last - first + 1;
    for (i = 0; i < pins.size(); i = i + 1)
      chk("wrap order", {29'h0, first} + i % n, {29'h0, pins[i]});
    axr(`OFS_FLAG, OK);
    chk("overwrite on repeat", 32'h1, {31'h0, rd[8 + first]});
    chk("last finished", 32'h1, {31'h0, rd[pins[pins.size() - 1]]});
    axw(`OFS_IRQ_EN, 32'h0, OK);
    chk("irq masked", 32'h0, {31'h0, irq_request});
    axw(`OFS_IRQ_EN, 32'h1 << (8 + first), OK);
    chk("irq raised", 32'h1, {31'h0, irq_request});
    axw(`OFS_FLAG, 32'hffff, OK);
    chk("irq cleared", 32'h0, {31'h0, irq_request});
    print_verdict;
  end
endmodule
bind sar_adc_sequencer_control sar_adc_checker mon_chk (.aclk, .aresetn, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .conv_clock, .core_sample, .core_convert, .analog_input_pin);
